// ---- logic/mpcfg_defines.svh ----
// constants of the multi-pin configuration and settings store
`ifndef MPCFG_DEFINES_SVH
`define MPCFG_DEFINES_SVH
`define MPCFG_CMD_MULTI_PIN      8'hF9
`define MPCFG_CMD_STORE_USER     8'h15
`define MPCFG_CMD_STORE_DEFAULT  8'h11
`define MPCFG_RST_STANDALONE     8'h04
`define MPCFG_RST_DROOP          8'h86
`define MPCFG_ROLE_HI            7
`define MPCFG_ROLE_LO            6
`define MPCFG_BIT_HIZ            5
`define MPCFG_BIT_TRACK          4
`define MPCFG_BIT_EXTREF         3
`define MPCFG_BIT_PGEN           2
`define MPCFG_BIT_RSVD           1
`define MPCFG_BIT_PULL           0
`define MPCFG_ROLE_STANDALONE    2'b00
`define MPCFG_ROLE_DROOP         2'b10
`define MPCFG_KEEP_MASK          8'hE7
`define MPCFG_DROOP_FORCE        8'h02
`define MPCFG_STORE_CYCLES       4'h8
`endif

// ---- logic/mpcfg_pkg.sv ----
// types of the multi-pin configuration and settings store
package mpcfg_pkg;
  typedef enum logic [4:0] {
    MPCFG_BOOT  = 5'b0_0001,
    MPCFG_LOAD  = 5'b0_0010,
    MPCFG_RUN   = 5'b0_0100,
    MPCFG_STORE = 5'b0_1000,
    MPCFG_DONE  = 5'b1_0000
  } mpcfg_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       send;
    logic [7:0] code;
    logic [7:0] data;
  } mpcfg_cmd_t;

  typedef struct packed {
    logic [1:0] role;
    logic       droop;
    logic       role_bad;
    logic       pg_en;
    logic       pg_hiz;
    logic       pull_en;
  } mpcfg_func_t;
endpackage

// ---- logic/mpcfg_decode.sv ----
// decodes the configuration byte into function selections
`timescale 1ns/1ns
`include "mpcfg_defines.svh"
module mpcfg_decode
  import mpcfg_pkg::*;
(
  // configuration byte
  input  wire logic [7:0]  cfg_in,
  // decoded functions
  output mpcfg_func_t      func_out
);
  always_comb begin
    func_out          = '0;
    func_out.role     = cfg_in[`MPCFG_ROLE_HI:`MPCFG_ROLE_LO];
    func_out.droop    = (func_out.role == `MPCFG_ROLE_DROOP);
    func_out.role_bad = !func_out.droop && (func_out.role != `MPCFG_ROLE_STANDALONE);
    func_out.pg_en    = cfg_in[`MPCFG_BIT_PGEN];
    func_out.pg_hiz   = cfg_in[`MPCFG_BIT_HIZ] && cfg_in[`MPCFG_BIT_PGEN];
    func_out.pull_en  = cfg_in[`MPCFG_BIT_PULL];
  end
endmodule

// ---- logic/mpcfg_store.sv ----
// multi-pin configuration register with factory and user setting sets
`timescale 1ns/1ns
`include "mpcfg_defines.svh"
module mpcfg_store
  import mpcfg_pkg::*;
#(
  parameter bit        DROOP_VARIANT = 1'b0,
  parameter int        WORDS         = 1,
  parameter bit [7:0]  FACTORY_CFG   = DROOP_VARIANT ? `MPCFG_RST_DROOP : `MPCFG_RST_STANDALONE
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // command port from the bus controller
  input  mpcfg_cmd_t       cmd_in,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  output logic             ack_out,
  output logic             nak_out,
  // non-volatile user area
  input  wire logic        nv_valid_in,
  input  wire logic [7:0]  nv_data_in,
  output logic             nv_write_out,
  output logic [7:0]       nv_data_out,
  // pins
  input  wire logic        on_off_active_low_in,
  input  wire logic        power_ok_in,
  output logic             power_ok_output_out,
  output logic             power_ok_output_oe_out,
  output logic             secondary_on_off_pull_up_out,
  output logic             secondary_on_off_pull_down_out,
  // status
  output mpcfg_func_t      func_out,
  output logic             busy_out,
  output logic             user_loaded_out
);
  // elaboration checks: one stored word, factory byte inside the supported set
  if (WORDS != 1) begin : g_bad_words
    $error("mpcfg_store serves exactly one word");
  end
  if (FACTORY_CFG[`MPCFG_BIT_TRACK:`MPCFG_BIT_EXTREF] != 2'b00) begin : g_bad_factory
    $error("factory configuration sets unsupported bits");
  end

  typedef struct packed {
    mpcfg_state_t state;
    logic [7:0]   cfg;
    logic [7:0]   nv_data;
    logic         nv_write;
    logic [3:0]   cnt;
    logic         user_loaded;
    logic [7:0]   rd_data;
    logic         rd_valid;
    logic         ack;
    logic         nak;
  } mpcfg_regs_t;

  mpcfg_regs_t r_r;
  mpcfg_regs_t r_nxt;
  mpcfg_func_t func;

  function automatic logic [7:0] mpcfg_sanitize(input logic [7:0] v);
    logic [7:0] o;
    // tracking and ext ref held zero
    o = v & `MPCFG_KEEP_MASK;
    if (o[`MPCFG_ROLE_HI:`MPCFG_ROLE_LO] == `MPCFG_ROLE_DROOP) begin
      o = o | `MPCFG_DROOP_FORCE;
    end
    return o;
  endfunction

  // a request of any kind on the command port
  function automatic logic mpcfg_any_req(input mpcfg_cmd_t c);
    return c.wr || c.rd || c.send;
  endfunction

  // a request aimed at one command code
  function automatic logic mpcfg_hit(input mpcfg_cmd_t c, input logic [7:0] code);
    return mpcfg_any_req(c) && (c.code == code);
  endfunction

  // the ack follows the last store cycle and the done state
  localparam int STORE_ACK_GAP = `MPCFG_STORE_CYCLES + 1;

  mpcfg_decode u_decode (
    .cfg_in   (r_r.cfg),
    .func_out (func)
  );

  always_comb begin
    r_nxt          = r_r;
    r_nxt.rd_valid = 1'b0;
    r_nxt.ack      = 1'b0;
    r_nxt.nak      = 1'b0;
    r_nxt.nv_write = 1'b0;
    case (r_r.state)
      MPCFG_BOOT: begin
        r_nxt.state = MPCFG_LOAD;
      end
      MPCFG_LOAD: begin
        // empty user area falls back to factory
        if (nv_valid_in) begin
          r_nxt.cfg         = mpcfg_sanitize(nv_data_in);
          r_nxt.user_loaded = 1'b1;
        end else begin
          r_nxt.cfg         = FACTORY_CFG;
          r_nxt.user_loaded = 1'b0;
        end
        r_nxt.state = MPCFG_RUN;
      end
      MPCFG_RUN: begin
        if (cmd_in.wr && cmd_in.code == `MPCFG_CMD_MULTI_PIN) begin
          r_nxt.cfg = mpcfg_sanitize(cmd_in.data);
          r_nxt.ack = 1'b1;
        end else if (cmd_in.rd && cmd_in.code == `MPCFG_CMD_MULTI_PIN) begin
          r_nxt.rd_data  = r_r.cfg;
          r_nxt.rd_valid = 1'b1;
          r_nxt.ack      = 1'b1;
        end else if (cmd_in.send && cmd_in.code == `MPCFG_CMD_STORE_USER) begin
          r_nxt.nv_data  = r_r.cfg;
          r_nxt.nv_write = 1'b1;
          r_nxt.cnt      = `MPCFG_STORE_CYCLES;
          r_nxt.state    = MPCFG_STORE;
        end else if (cmd_in.send && cmd_in.code == `MPCFG_CMD_STORE_DEFAULT) begin
          r_nxt.nak = 1'b1;
        end else if (mpcfg_any_req(cmd_in)) begin
          r_nxt.nak = 1'b1;
        end
      end
      MPCFG_STORE: begin
        if (r_r.cnt == 4'h1) begin
          r_nxt.state = MPCFG_DONE;
        end
        r_nxt.cnt = r_r.cnt - 4'h1;
      end
      MPCFG_DONE: begin
        r_nxt.ack   = 1'b1;
        r_nxt.state = MPCFG_RUN;
      end
      default: begin
        r_nxt.state = MPCFG_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_r          <= '0;
      r_r.state    <= MPCFG_BOOT;
      r_r.cfg      <= DROOP_VARIANT ? `MPCFG_RST_DROOP : `MPCFG_RST_STANDALONE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rd_data_out    = r_r.rd_data;
  assign rd_valid_out   = r_r.rd_valid;
  assign ack_out        = r_r.ack;
  assign nak_out        = r_r.nak;
  assign nv_write_out   = r_r.nv_write;
  assign nv_data_out    = r_r.nv_data;
  assign busy_out       = (r_r.state != MPCFG_RUN);
  assign user_loaded_out = r_r.user_loaded;
  assign func_out       = func;

  // power ok drive: push-pull drives both levels, high-z releases when active (high)
  always_comb begin
    power_ok_output_out    = power_ok_in;
    power_ok_output_oe_out = 1'b0;
    if (func.pg_en) begin
      power_ok_output_oe_out = func.pg_hiz ? !power_ok_in : 1'b1;
    end
  end

  assign secondary_on_off_pull_up_out   = func.pull_en && on_off_active_low_in;
  assign secondary_on_off_pull_down_out = func.pull_en && !on_off_active_low_in;

  AST_WRITE_APPLIED: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_RUN && cmd_in.wr && cmd_in.code == `MPCFG_CMD_MULTI_PIN)
    |=> (r_r.cfg == mpcfg_sanitize($past(cmd_in.data)) && ack_out))
    else $error("written configuration not applied");
  AST_ROLE_DECODE: assert property (@(posedge clk_in) disable iff (rst_in)
    (func.droop == (r_r.cfg[`MPCFG_ROLE_HI:`MPCFG_ROLE_LO] == `MPCFG_ROLE_DROOP))
    && (!func.droop || r_r.cfg[`MPCFG_BIT_RSVD]))
    else $error("role decode wrong");
  AST_HIZ_RELEASE: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.cfg[`MPCFG_BIT_HIZ] && r_r.cfg[`MPCFG_BIT_PGEN] && power_ok_in) |-> !power_ok_output_oe_out)
    else $error("high-z power ok driven while active");
  AST_PUSH_PULL: assert property (@(posedge clk_in) disable iff (rst_in)
    (!r_r.cfg[`MPCFG_BIT_HIZ] && r_r.cfg[`MPCFG_BIT_PGEN])
    |-> (power_ok_output_oe_out && power_ok_output_out == power_ok_in))
    else $error("push-pull power ok not driven");
  AST_PULL_DIR: assert property (@(posedge clk_in) disable iff (rst_in)
    r_r.cfg[`MPCFG_BIT_PULL] |-> (secondary_on_off_pull_up_out == on_off_active_low_in
      && secondary_on_off_pull_down_out != on_off_active_low_in))
    else $error("pull direction wrong");
  AST_PULL_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    !r_r.cfg[`MPCFG_BIT_PULL] |-> !(secondary_on_off_pull_up_out || secondary_on_off_pull_down_out))
    else $error("pull active while disabled");
  AST_RESET_VALUE: assert property (@(posedge clk_in)
    $fell(rst_in) |-> r_r.cfg == (DROOP_VARIANT ? `MPCFG_RST_DROOP : `MPCFG_RST_STANDALONE))
    else $error("reset configuration wrong");
  AST_BOOT_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_LOAD && !nv_valid_in) |=> (r_r.cfg == FACTORY_CFG && !user_loaded_out))
    else $error("factory set not loaded");
  AST_USER_PRIO: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_LOAD && nv_valid_in) |=> user_loaded_out)
    else $error("user set not preferred");
  AST_STORE_USER: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_RUN && cmd_in.send && cmd_in.code == `MPCFG_CMD_STORE_USER)
    |=> (nv_write_out && nv_data_out == $past(r_r.cfg)) ##STORE_ACK_GAP ack_out)
    else $error("store user sequence wrong");
  AST_DEFAULT_LOCK: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_RUN && cmd_in.send && cmd_in.code == `MPCFG_CMD_STORE_DEFAULT)
    |=> (nak_out && !nv_write_out && $stable(r_r.cfg)))
    else $error("store default not rejected");
  AST_NA_BITS: assert property (@(posedge clk_in) disable iff (rst_in)
    r_r.cfg[`MPCFG_BIT_TRACK:`MPCFG_BIT_EXTREF] == 2'b00)
    else $error("unsupported bits set");

  // command port and user area write checks
  AST_ACK_NAK_EXCL: assert property (@(posedge clk_in) disable iff (rst_in)
    !(ack_out && nak_out))
    else $error("ack and nak together");
  AST_READ_BACK: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_RUN && !cmd_in.wr && cmd_in.rd
      && cmd_in.code == `MPCFG_CMD_MULTI_PIN)
    |=> (rd_valid_out && ack_out && rd_data_out == $past(r_r.cfg)))
    else $error("read back wrong");
  AST_UNKNOWN_NAK: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_RUN && mpcfg_any_req(cmd_in)
      && !mpcfg_hit(cmd_in, `MPCFG_CMD_MULTI_PIN)
      && !mpcfg_hit(cmd_in, `MPCFG_CMD_STORE_USER))
    |=> (nak_out && !ack_out && $stable(r_r.cfg)))
    else $error("unknown command not refused");
  AST_BUSY_IGNORED: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_STORE || r_r.state == MPCFG_DONE)
    |=> ($stable(r_r.cfg) && !nak_out && !rd_valid_out))
    else $error("request taken while busy");
  AST_DONE_ACK: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_DONE) |=> (ack_out && !busy_out))
    else $error("store not acknowledged");
  AST_NV_PULSE: assert property (@(posedge clk_in) disable iff (rst_in)
    nv_write_out |=> !nv_write_out)
    else $error("flash write longer than one cycle");
  AST_STORE_BUSY: assert property (@(posedge clk_in) disable iff (rst_in)
    nv_write_out |-> busy_out)
    else $error("flash write outside the store sequence");
  // reset clears the held bytes, so the hold checks wait for a clean cycle after it
  AST_NV_DATA_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && !$past(rst_in) && !nv_write_out) |-> $stable(nv_data_out))
    else $error("stored byte changed without a write");
  AST_RD_DATA_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rst_in && !$past(rst_in) && !rd_valid_out) |-> $stable(rd_data_out))
    else $error("read byte changed without a read");

  // boot checks
  AST_BOOT_SEQ: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_BOOT && !rst_in)
    |=> (r_r.state == MPCFG_LOAD) ##1 (r_r.state == MPCFG_RUN))
    else $error("boot sequence wrong");
  AST_LOAD_USER_BYTE: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.state == MPCFG_LOAD && nv_valid_in)
    |=> r_r.cfg == mpcfg_sanitize($past(nv_data_in)))
    else $error("user set not loaded");

  // pin and role flag checks
  AST_PG_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    !r_r.cfg[`MPCFG_BIT_PGEN] |-> !power_ok_output_oe_out)
    else $error("power ok driven while disabled");
  AST_HIZ_LOW: assert property (@(posedge clk_in) disable iff (rst_in)
    (r_r.cfg[`MPCFG_BIT_HIZ] && r_r.cfg[`MPCFG_BIT_PGEN] && !power_ok_in)
    |-> power_ok_output_oe_out)
    else $error("high-z power ok not driven low while inactive");
  AST_PULL_EXCL: assert property (@(posedge clk_in) disable iff (rst_in)
    !(secondary_on_off_pull_up_out && secondary_on_off_pull_down_out))
    else $error("pull up and pull down together");
  AST_ROLE_FLAG: assert property (@(posedge clk_in) disable iff (rst_in)
    func.role_bad == (r_r.cfg[`MPCFG_ROLE_HI:`MPCFG_ROLE_LO] != `MPCFG_ROLE_STANDALONE
      && r_r.cfg[`MPCFG_ROLE_HI:`MPCFG_ROLE_LO] != `MPCFG_ROLE_DROOP))
    else $error("unsupported role not flagged");
endmodule

// ---- sim/mpcfg_flash_model.sv ----
// behavioural non-volatile user area beside the settings store
`timescale 1ns/1ns
module mpcfg_flash_model (
  // clock
  input  wire logic       clk_in,
  // store request from the device
  input  wire logic       write_in,
  input  wire logic [7:0] data_in,
  // stored contents
  output logic            valid_out,
  output logic [7:0]      data_out
);
  logic [7:0] mem_r;
  logic [7:0] junk_r;
  initial begin
    valid_out = 1'b0;
    mem_r     = 8'h00;
    junk_r    = 8'h5A;
  end
  always @(posedge clk_in) begin
    junk_r <= ~junk_r;
    if (write_in) begin
      mem_r     <= data_in;
      valid_out <= 1'b1;
    end
  end
  // an empty area shows a changing pattern, never a stale byte
  assign data_out = valid_out ? mem_r : junk_r;
endmodule

// ---- sim/testbench.sv ----
// self-checking bench of the multi-pin configuration store
`timescale 1ns/1ns
module testbench;
  import mpcfg_pkg::*;
  logic        clk_in, rst_in, nv_v, nv_w, pal, pok, pin, oe, pu, pd;
  logic        rv, ack, nak, busy, uload;
  logic        vld, bsy;
  logic [7:0]  rdat_d, got_d;
  logic [7:0]  rdat, nv_d, nv_q;
  mpcfg_cmd_t  cmd;
  mpcfg_func_t func;
  int          n_errors, comparisons;
  logic [1:0]  res;
  logic [7:0]  got;

  mpcfg_store u_dut (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd), .rd_data_out(rdat),
    .rd_valid_out(rv), .ack_out(ack), .nak_out(nak), .nv_valid_in(nv_v), .nv_data_in(nv_q),
    .nv_write_out(nv_w), .nv_data_out(nv_d), .on_off_active_low_in(pal), .power_ok_in(pok),
    .power_ok_output_out(pin), .power_ok_output_oe_out(oe),
    .secondary_on_off_pull_up_out(pu), .secondary_on_off_pull_down_out(pd),
    .func_out(func), .busy_out(busy), .user_loaded_out(uload));
  mpcfg_flash_model u_nv (.clk_in(clk_in), .write_in(nv_w), .data_in(nv_d),
    .valid_out(nv_v), .data_out(nv_q));
  // droop share variant beside it, no user data: only its boot value is judged
  mpcfg_store #(.DROOP_VARIANT(1'b1)) u_dut_droop (.clk_in(clk_in), .rst_in(rst_in),
    .cmd_in(cmd), .rd_data_out(rdat_d), .rd_valid_out(), .ack_out(), .nak_out(),
    .nv_valid_in(1'b0), .nv_data_in(8'h00), .nv_write_out(), .nv_data_out(),
    .on_off_active_low_in(pal), .power_ok_in(pok), .power_ok_output_out(),
    .power_ok_output_oe_out(), .secondary_on_off_pull_up_out(),
    .secondary_on_off_pull_down_out(), .func_out(), .busy_out(), .user_loaded_out());

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // power cycle: the flash model keeps its contents
  task automatic power_up();
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  // one command, then wait for ack or nak; rd_data sampled at that edge
  task automatic command(input logic w, r, s, input logic [7:0] c, d);
    int i;
    cmd <= '{w, r, s, c, d};
    @(posedge clk_in);
    cmd <= '0;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (i == 0) bsy = busy;
      if (ack === 1'b1 || nak === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      test_done();
    end
    res = {ack, nak};
    got = rdat;
    vld = rv;
    got_d = rdat_d;
  endtask

  task automatic wr_rd(input logic [7:0] v, input logic [7:0] exp);
    command(1'b1, 1'b0, 1'b0, 8'hF9, v);
    chk("write ack", 8'h02, {6'h00, res});
    command(1'b0, 1'b1, 1'b0, 8'hF9, 8'h00);
    chk("config", exp, got);
    chk("read valid", 8'h01, {7'h00, vld});
  endtask

  task automatic boot_empty();
    command(1'b0, 1'b1, 1'b0, 8'hF9, 8'h00);
    chk("reset config", 8'h04, got);
    chk("droop reset config", 8'h86, got_d);
    chk("user loaded", 8'h00, {7'h00, uload});
  endtask

  task automatic pin_table();
    logic [7:0] v[6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h24, 8'h25};
    for (int i = 0; i < 6; i++) begin
      pal <= i[1];
      pok <= i[0];
      wr_rd(v[i], v[i]);
      chk("pins", {4'h0, v[i][2] & ~(v[i][5] & i[0]), v[i][0] & i[1],
        v[i][0] & ~i[1], 1'(i[0])}, {4'h0, oe, pu, pd, pin});
    end
  endtask

  task automatic roles();
    wr_rd(8'h98, 8'h82);
    chk("droop func", 8'h50, {1'b0, func});
    wr_rd(8'h40, 8'h40);
    chk("bad role func", 8'h28, {1'b0, func});
    wr_rd(8'hC5, 8'hC5);
    chk("top role func", 8'h6D, {1'b0, func});
  endtask

  task automatic refusals();
    wr_rd(8'h24, 8'h24);
    command(1'b0, 1'b0, 1'b1, 8'h11, 8'h00);
    chk("store default", 8'h01, {6'h00, res});
    command(1'b1, 1'b0, 1'b0, 8'h22, 8'h55);
    chk("unknown code", 8'h01, {6'h00, res});
    command(1'b0, 1'b1, 1'b0, 8'hF9, 8'h00);
    chk("kept config", 8'h24, got);
  endtask

  task automatic store_user();
    wr_rd(8'h25, 8'h25);
    command(1'b0, 1'b0, 1'b1, 8'h15, 8'h00);
    chk("store ack", 8'h02, {6'h00, res});
    chk("busy while storing", 8'h01, {7'h00, bsy});
    chk("stored byte", 8'h25, nv_d);
    power_up();
    command(1'b0, 1'b1, 1'b0, 8'hF9, 8'h00);
    chk("user config", 8'h25, got);
    chk("user loaded", 8'h01, {7'h00, uload});
  endtask

  initial begin
    n_errors    = 0;
    comparisons = 0;
    rst_in      = 1'b1;
    cmd         = '0;
    pal         = 1'b1;
    pok         = 1'b1;
    power_up();
    boot_empty();
    pin_table();
    roles();
    refusals();
    store_user();
    test_done();
  end
endmodule
